//--- hdl/pmic_interrupt_control_status.sv
// PCI interrupt control/status register and INTA request
// Assumes a single-cycle register port on clk_sys and synchronous add-on strobes
`timescale 1ns/1ps
`include "pmic_params.svh"
module pmic_interrupt_control_status
    import pmic_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // PCI register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [3:0]  reg_be,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    // Add-on side events
    input  wire pmic_lane_t  in_mbox_wr_lanes,
    input  wire pmic_lane_t  out_mbox_rd_lanes,
    input  wire logic        addon_irq_in_n,
    // PCI interrupt
    output wire logic        inta_n,
    output wire logic        inta_oe
);
    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Write strobe of one byte lane of the register
    function automatic logic lane_write(
        input logic           wr,
        input logic           hit,
        input pmic_lane_t     be,
        input pmic_byte_sel_t lane
    );
        lane_write = wr & hit & be[lane];
    endfunction : lane_write

    // Sticky flag; an event in the clearing cycle still sets it
    function automatic logic sticky_next(
        input logic ev,
        input logic flag,
        input logic clr
    );
        sticky_next = ev | (flag & ~clr);
    endfunction : sticky_next

    // One control bit: load on its lane write, else hold
    function automatic logic load_bit(
        input logic we,
        input logic d,
        input logic q
    );
        load_bit = we ? d : q;
    endfunction : load_bit

    // Byte select field: load on its lane write, else hold
    function automatic pmic_byte_sel_t load_sel(
        input logic           we,
        input pmic_byte_sel_t d,
        input pmic_byte_sel_t q
    );
        load_sel = we ? d : q;
    endfunction : load_sel

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic                addon_en;
    logic                in_en;
    logic                out_en;
    pmic_byte_sel_t      in_sel;
    pmic_byte_sel_t      out_sel;
    logic                in_flag;
    logic                out_flag;
    logic                addon_flag;
    logic [31:0]         csr_view;

    // ------------------------------------------------------------
    // Decode nets
    // ------------------------------------------------------------
    wire logic           sel_reg;
    wire logic           wr_b0;
    wire logic           wr_b1;
    wire logic           wr_b2;
    wire logic           in_hit;
    wire logic           out_hit;
    wire logic           clr_in;
    wire logic           clr_out;
    wire logic           summary;
    wire logic           next_in_flag;
    wire logic           next_out_flag;
    wire logic           next_addon_flag;
    wire pmic_byte_sel_t next_out_sel;
    wire logic           next_out_en;
    wire pmic_byte_sel_t next_in_sel;
    wire logic           next_in_en;
    wire logic           next_addon_en;
    wire logic [31:0]    next_rdata;

    // ------------------------------------------------------------
    // Register select and byte lanes
    // ------------------------------------------------------------
    // Byte 3 has no storage, so writes to it vanish
    assign sel_reg = reg_addr == `PMIC_INTERRUPT_CONTROL_STATUS_OFFSET;
    assign wr_b0   = lane_write(reg_wr, sel_reg, reg_be, 2'h0);
    assign wr_b1   = lane_write(reg_wr, sel_reg, reg_be, 2'h1);
    assign wr_b2   = lane_write(reg_wr, sel_reg, reg_be, 2'h2);

    // ------------------------------------------------------------
    // Mailbox byte match
    // ------------------------------------------------------------
    pmic_lane_match u_in_match (
        .enable (in_en),
        .sel    (in_sel),
        .lanes  (in_mbox_wr_lanes),
        .hit    (in_hit)
    );

    pmic_lane_match u_out_match (
        .enable (out_en),
        .sel    (out_sel),
        .lanes  (out_mbox_rd_lanes),
        .hit    (out_hit)
    );

    // ------------------------------------------------------------
    // Sticky mailbox flags, set wins over clear
    // ------------------------------------------------------------
    assign clr_in        = wr_b2 & reg_wdata[`PMIC_BIT_IN_FLAG];
    assign clr_out       = wr_b2 & reg_wdata[`PMIC_BIT_OUT_FLAG];
    assign next_in_flag  = sticky_next(in_hit, in_flag, clr_in);
    assign next_out_flag = sticky_next(out_hit, out_flag, clr_out);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            in_flag  <= 1'h0;
            out_flag <= 1'h0;
        end else begin
            in_flag  <= next_in_flag;
            out_flag <= next_out_flag;
        end
    end

    // ------------------------------------------------------------
    // Add-on request flag
    // ------------------------------------------------------------
    // Level copy of the pin, not write-one-clear; drops on release
    assign next_addon_flag = ~addon_irq_in_n;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            addon_flag <= 1'h0;
        end else begin
            addon_flag <= next_addon_flag;
        end
    end

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    assign next_out_sel  = load_sel(wr_b0, reg_wdata[`PMIC_OUT_SEL_HI:`PMIC_OUT_SEL_LO], out_sel);
    assign next_out_en   = load_bit(wr_b0, reg_wdata[`PMIC_BIT_OUT_EN], out_en);
    assign next_in_sel   = load_sel(wr_b1, reg_wdata[`PMIC_IN_SEL_HI:`PMIC_IN_SEL_LO], in_sel);
    assign next_in_en    = load_bit(wr_b1, reg_wdata[`PMIC_BIT_IN_EN], in_en);
    assign next_addon_en = load_bit(wr_b1, reg_wdata[`PMIC_BIT_ADDON_EN], addon_en);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            out_sel <= 2'h0;
            out_en  <= 1'h0;
        end else begin
            out_sel <= next_out_sel;
            out_en  <= next_out_en;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            in_sel   <= 2'h0;
            in_en    <= 1'h0;
            addon_en <= 1'h0;
        end else begin
            in_sel   <= next_in_sel;
            in_en    <= next_in_en;
            addon_en <= next_addon_en;
        end
    end

    // ------------------------------------------------------------
    // Summary and INTA
    // ------------------------------------------------------------
    // Open-drain pin: enable is high only while pulling low
    assign summary = in_flag | out_flag | (addon_flag & addon_en);
    assign inta_n  = ~summary;
    assign inta_oe = summary;

    // ------------------------------------------------------------
    // Read view
    // ------------------------------------------------------------
    always_comb begin
        csr_view = `PMIC_ONES_MASK;
        csr_view[`PMIC_BIT_SUMMARY]    = summary;
        csr_view[`PMIC_BIT_ADDON_FLAG] = addon_flag;
        csr_view[`PMIC_BIT_IN_FLAG]    = in_flag;
        csr_view[`PMIC_BIT_OUT_FLAG]   = out_flag;
        csr_view[`PMIC_BIT_ADDON_EN]   = addon_en;
        csr_view[`PMIC_BIT_IN_EN]      = in_en;
        csr_view[`PMIC_IN_SEL_HI:`PMIC_IN_SEL_LO]   = in_sel;
        csr_view[`PMIC_BIT_OUT_EN]     = out_en;
        csr_view[`PMIC_OUT_SEL_HI:`PMIC_OUT_SEL_LO] = out_sel;
    end

    // Unmapped offsets read as zero
    assign next_rdata = sel_reg ? csr_view : 32'h00000000;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rdata <= `PMIC_INTERRUPT_CONTROL_STATUS_RESET;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule : pmic_interrupt_control_status

//--- hdl/pmic_lane_match.sv
// Byte lane selector: hit when the selected lane is accessed with enable
// Assumes lane strobes are one-cycle pulses on clk_sys
`timescale 1ns/1ps
module pmic_lane_match
    import pmic_pkg::*;
(
    // Selection
    input  wire logic           enable,
    input  wire pmic_byte_sel_t sel,
    // Access
    input  wire pmic_lane_t     lanes,
    output wire logic           hit
);
    wire logic lane_bit;
    assign lane_bit = lanes[sel];
    assign hit      = enable & lane_bit;
endmodule : pmic_lane_match

//--- hdl/pmic_params.svh
// Constants of the PCI-side interrupt control and status register
// Assumes the includer provides package/module scope for the types
// How it works
// - Summary bit ORs mailbox flags and gated addon
// - Disabled addon request never raises interrupt
// - Addon flag follows low addon interrupt input
// - Enabled active addon request drives INTA low
// - Selected incoming byte write sets incoming flag
// - Writing one clears incoming flag
// - Selected outgoing byte read sets outgoing flag
// - Writing one clears outgoing flag
// - Addon enable gates INTA only, not flag
// - Incoming enable lets selected write interrupt
// - Incoming select picks byte zero to three
// - Outgoing enable lets selected read interrupt
// - Outgoing select picks byte zero to three
// - Bits 11:10 and 3:2 read one
`ifndef PMIC_PARAMS_SVH
`define PMIC_PARAMS_SVH

`define PMIC_INTERRUPT_CONTROL_STATUS_OFFSET   8'h38
`define PMIC_INTERRUPT_CONTROL_STATUS_RESET    32'h00000C0C
`define PMIC_BIT_SUMMARY     23
`define PMIC_BIT_ADDON_FLAG  22
`define PMIC_BIT_IN_FLAG     17
`define PMIC_BIT_OUT_FLAG    16
`define PMIC_BIT_ADDON_EN    13
`define PMIC_BIT_IN_EN       12
`define PMIC_IN_SEL_HI       9
`define PMIC_IN_SEL_LO       8
`define PMIC_BIT_OUT_EN      4
`define PMIC_OUT_SEL_HI      1
`define PMIC_OUT_SEL_LO      0
`define PMIC_ONES_MASK       32'h00000C0C

`endif

//--- hdl/pmic_pkg.sv
// Types shared by the interrupt control block
// Assumes pmic_params.svh is on the include path
package pmic_pkg;
    typedef logic [1:0] pmic_byte_sel_t;
    typedef logic [3:0] pmic_lane_t;
endpackage : pmic_pkg

//--- tb/pci_mailbox_interrupt_ctrl_tb.sv
// Bench for pmic_interrupt_control_status
// Assumes pmic_addon_model as add-on side
`timescale 1ns/1ps
module pci_mailbox_interrupt_ctrl_tb;
    logic clk_sys, rst_b, reg_wr, addon_irq_in_n, inta_n, inta_oe, h;
    logic [7:0] reg_addr;
    logic [3:0] reg_be, in_l, out_l;
    logic [31:0] reg_wdata, reg_rdata, c, e;
    // Row: hit expected, incoming side, enable, select, lane pulsed
    logic [6:0] rows [10] = '{7'h70, 7'h75, 7'h7A, 7'h7F, 7'h50, 7'h55, 7'h5A, 7'h5F, 7'h39, 7'h2F};
    int err_count, total_checks;
    pmic_interrupt_control_status pmic_interrupt_control_status_i (.clk_sys, .rst_b, .reg_addr, .reg_wr, .reg_be, .reg_wdata, .reg_rdata,
        .in_mbox_wr_lanes(in_l), .out_mbox_rd_lanes(out_l), .addon_irq_in_n, .inta_n, .inta_oe);
    pmic_addon_model pmic_addon_model_i (.clk_sys, .in_mbox_wr_lanes(in_l), .out_mbox_rd_lanes(out_l),
        .addon_irq_in_n);
    initial begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input string n, input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", n, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] be, input logic [31:0] d);
        @(negedge clk_sys);
        {reg_wr, reg_be, reg_wdata} = {1'b1, be, d};
        @(negedge clk_sys);
        reg_wr = 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge clk_sys);
        reg_addr = a;
        @(negedge clk_sys);
        chk("rdata", reg_rdata, e);
        reg_addr = 8'h38;
    endtask : rd
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        #1000000;
        err_count++;
        wrap_up;
    end
    initial begin
        {rst_b, reg_wr, reg_be, reg_wdata} = '0;
        reg_addr = 8'h38;
        repeat (12) @(negedge clk_sys);
        rst_b = 1;
        rd(8'h38, 32'hC0C);
        foreach (rows[i]) begin
            c = rows[i][5] ? 32'(rows[i][4]) << 12 | 32'(rows[i][3:2]) << 8
                           : 32'(rows[i][4]) << 4 | 32'(rows[i][3:2]);
            h = rows[i][6];
            wr(4'h3, c);
            pmic_addon_model_i.pulse(rows[i][5], rows[i][1:0]);
            e = 32'hC0C | c | (h ? (rows[i][5] ? 32'h820000 : 32'h810000) : 32'h0);
            rd(8'h38, e);
            chk("inta_n", 32'(inta_n), 32'(!h));
            chk("inta_oe", 32'(inta_oe), 32'(h));
            wr(4'h4, 32'h30000);
        end
        wr(4'hF, 32'hFFFFFFFF);
        rd(8'h38, 32'h3F1F);
        pmic_addon_model_i.irq(0);
        rd(8'h38, 32'hC03F1F);
        chk("inta_n", 32'(inta_n), 32'h0);
        wr(4'h2, 32'h0);
        rd(8'h38, 32'h400C1F);
        chk("inta_n", 32'(inta_n), 32'h1);
        pmic_addon_model_i.pulse(0, 2'h3);
        wr(4'h4, 32'h0);
        rd(8'h38, 32'hC10C1F);
        pmic_addon_model_i.irq(1);
        wr(4'h4, 32'h10000);
        rd(8'h38, 32'hC1F);
        fork
            pmic_addon_model_i.pulse(0, 2'h3);
            wr(4'h4, 32'h10000);
        join
        rd(8'h38, 32'h810C1F);
        chk("inta_n", 32'(inta_n), 32'h0);
        rd(8'h3C, 32'h0);
        rst_b = 0;
        @(negedge clk_sys);
        rst_b = 1;
        rd(8'h38, 32'hC0C);
        chk("inta_n", 32'(inta_n), 32'h1);
        wrap_up;
    end
endmodule : pci_mailbox_interrupt_ctrl_tb

//--- tb/pmic_addon_model.sv
// Add-on side: mailbox lane strobes and interrupt pin
// Assumes drive on falling clk_sys
`timescale 1ns/1ps
module pmic_addon_model
    import pmic_pkg::*;
(
    input  wire logic clk_sys,
    output pmic_lane_t in_mbox_wr_lanes,
    output pmic_lane_t out_mbox_rd_lanes,
    output logic       addon_irq_in_n
);
    initial {in_mbox_wr_lanes, out_mbox_rd_lanes, addon_irq_in_n} = 9'h001;
    task automatic pulse(input logic wr, input logic [1:0] n);
        @(negedge clk_sys);
        if (wr) in_mbox_wr_lanes = 4'h1 << n; else out_mbox_rd_lanes = 4'h1 << n;
        @(negedge clk_sys);
        {in_mbox_wr_lanes, out_mbox_rd_lanes} = 8'h00;
    endtask : pulse
    task automatic irq(input logic lvl);
        @(negedge clk_sys);
        addon_irq_in_n = lvl;
    endtask : irq
endmodule : pmic_addon_model

//--- tb/pmic_interrupt_control_status_monitor.sv
// Port checker for pmic_interrupt_control_status
// Assumes bind to the top module
`timescale 1ns/1ps
module pmic_mon
    import pmic_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [3:0]  reg_be,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    // Add-on side
    input wire pmic_lane_t  in_mbox_wr_lanes,
    input wire pmic_lane_t  out_mbox_rd_lanes,
    input wire logic        addon_irq_in_n,
    // Interrupt pin
    input wire logic        inta_n,
    input wire logic        inta_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_pin_read; !addon_irq_in_n ##1 reg_addr == 8'h38; endsequence
    sequence s_clear; reg_wr && reg_addr == 8'h38 && reg_be[2] && reg_wdata[17:16] == 2'b11; endsequence
    chk_oe_level:
        assert property (inta_oe == !inta_n) else $error("oe vs inta");
    chk_addon_flag:
        assert property (s_pin_read |=> reg_rdata[22]) else $error("addon flag");
    chk_summary_or:
        assert property (reg_addr == 8'h38 |=> reg_rdata[23] ==
            (reg_rdata[17] | reg_rdata[16] | reg_rdata[22] & reg_rdata[13])) else $error("summary");
    chk_inta_summary:
        assert property (reg_addr == 8'h38 |=> reg_rdata[23] == !$past(inta_n)) else $error("inta");
    chk_fixed_bits:
        assert property (reg_addr == 8'h38 |=> (reg_rdata & 32'hFF3CCCEC) == 32'h00000C0C)
            else $error("fixed bits");
    chk_rise_cause:
        assert property ($rose(inta_oe) |-> $past(in_mbox_wr_lanes | out_mbox_rd_lanes) != 4'h0
            || !$past(addon_irq_in_n) || $past(reg_wr)) else $error("rise cause");
    chk_w1c_clear:
        assert property (s_clear and (addon_irq_in_n && (in_mbox_wr_lanes | out_mbox_rd_lanes) == 4'h0)
            |=> !inta_oe) else $error("w1c");
    chk_unmapped_zero:
        assert property (reg_addr != 8'h38 |=> reg_rdata == 32'h0) else $error("unmapped");
endmodule : pmic_mon
bind pmic_interrupt_control_status pmic_mon pmic_mon_i (
    .clk_sys           (clk_sys),
    .rst_b             (rst_b),
    .reg_addr          (reg_addr),
    .reg_wr            (reg_wr),
    .reg_be            (reg_be),
    .reg_wdata         (reg_wdata),
    .reg_rdata         (reg_rdata),
    .in_mbox_wr_lanes  (in_mbox_wr_lanes),
    .out_mbox_rd_lanes (out_mbox_rd_lanes),
    .addon_irq_in_n    (addon_irq_in_n),
    .inta_n            (inta_n),
    .inta_oe           (inta_oe)
);
